// [hlt_timer_map.svh]
// Register offsets, reset values and fixed codes of the limit timer
`ifndef HLT_TIMER_MAP_SVH
`define HLT_TIMER_MAP_SVH
`define HLT_OFS_MAIN 8'h00
`define HLT_OFS_CLKSEL 8'h04
`define HLT_OFS_COUNT 8'h08
`define HLT_OFS_PERIOD 8'h0c
`define HLT_OFS_LIMIT 8'h10
`define HLT_OFS_EXT_RESET_SOURCE_SEL 8'h14
`define HLT_RST_MAIN 8'h00
`define HLT_RST_CLKSEL 4'h0
`define HLT_RST_COUNT 8'h00
`define HLT_RST_PERIOD 8'hff
`define HLT_RST_LIMIT 8'h00
`define HLT_RST_EXT_RESET_SOURCE_SEL 4'h0
`define HLT_CS_INSTR 4'h0
`define HLT_CS_FIRST_RSVD 4'hd
`define HLT_EXT_RESET_SOURCE_SEL_RSVD 4'hf
`define HLT_PRE_ONE 7'h01
`endif

// [hlt_pkg.sv]
// Types shared by the limit timer control logic
package hlt_pkg;

typedef struct packed {
    logic on;
    logic [2:0] prescale_select;
    logic [3:0] postscale_select;
} hlt_main_s;

typedef struct packed {
    logic prescaler_sync_enable;
    logic input_clock_polarity;
    logic enable_sync_to_timer_clock;
    logic [4:0] mode;
} hlt_limit_s;

typedef enum logic [4:0] {
    HLT_MODE_FREE = 5'h00,
    HLT_MODE_EDGE_RISE = 5'h11,
    HLT_MODE_EDGE_FALL = 5'h12,
    HLT_MODE_EDGE_BOTH = 5'h13,
    HLT_MODE_LVL_LOW = 5'h16,
    HLT_MODE_LVL_HIGH = 5'h17
} hlt_mode_e;

typedef enum logic [1:0] {
    HLT_IDLE = 2'b00,
    HLT_RUN = 2'b01,
    HLT_HELD = 2'b10
} hlt_run_e;

endpackage : hlt_pkg

// [hlt_sync.sv]
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module hlt_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

generate
    if (WIDTH < 1)
    begin : g_bad_width
        $error("hlt_sync width must be at least one");
    end
endgenerate

logic [WIDTH-1:0] meta_q;
logic [WIDTH-1:0] meta_d;
logic [WIDTH-1:0] stable_q;
logic [WIDTH-1:0] stable_d;

// First stage feeds only the second stage
always_comb
begin
    meta_d = async_in;
    stable_d = meta_q;
end

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        meta_q <= '0;
        stable_q <= '0;
    end
    else
    begin
        meta_q <= meta_d;
        stable_q <= stable_d;
    end
end

assign sync_out = stable_q;

endmodule : hlt_sync
`default_nettype wire

// [hlt_timer_ctrl.sv]
// Control and count logic of the 8-bit period timer with hardware limit
//
// What this block does
// - Prescaler output goes through a two-stage sync when prescaler sync set
// - With prescaler sync, count reads always return a coherent value
// - With prescaler sync set, the timer does not advance during sleep
// - Polarity bit picks falling (1) or rising (0) input clock edge
// - Enable-sync bit resynchronises the on bit to the timer clock
// - With enable sync, counting starts two timer clocks after on is set
// - Five-bit mode field in limit register bits 4 to 0
// - By default count runs while on is 1 and holds its value when 0
// - When count equals period, the next timer clock clears the count
// - Four-bit reset source selector in bits 3..0, upper bits read zero
// - Selector maps pin, comparators, captures, siblings, zero-cross, cells, PWM
// - Limit and reset-select bits are read/write and reset to zero
// - Clearing on resets prescaler, postscaler and state; count is kept unless a level mode sees its reset level
// - Prescale field divides the input clock by 1 up to 128
`timescale 1ns/10ps
`default_nettype none
`include "hlt_timer_map.svh"
module hlt_timer_ctrl
    import hlt_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int OWN_EXT_RESET_SOURCE_SEL_CODE = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_sleep,
    input wire logic [15:0] clock_sources,
    input wire logic [15:0] ext_reset_sources,
    output logic period_match_out,
    output logic postscaled_out
);

generate
    if (ADDR_W < 8 || OWN_EXT_RESET_SOURCE_SEL_CODE < 5 || OWN_EXT_RESET_SOURCE_SEL_CODE > 7)
    begin : g_bad_param
        $error("hlt_timer_ctrl parameters out of range");
    end
endgenerate

// ============================================================
// Input synchronisers
// ============================================================
logic [15:0] clk_src_s;
logic [15:0] ext_src_s;

hlt_sync #(.WIDTH(16)) u_sync_clk (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(clock_sources),
    .sync_out(clk_src_s)
);

hlt_sync #(.WIDTH(16)) u_sync_ext (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(ext_reset_sources),
    .sync_out(ext_src_s)
);

// ============================================================
// APB slave and registers
// ============================================================
hlt_main_s main_q, main_d;
hlt_limit_s limit_q, limit_d;
logic [3:0] clksel_q, clksel_d;
logic [3:0] ext_reset_source_sel_q, ext_reset_source_sel_d;
logic [7:0] period_q, period_d;
logic [7:0] count_q, count_d;
logic [31:0] prdata_q, prdata_d;
logic pready_q, pready_d;
logic pslverr_q, pslverr_d;
logic [7:0] addr8;
logic hit;
logic wr;
logic hw_off;

assign addr8 = paddr[7:0];
assign hit = (addr8 == `HLT_OFS_MAIN) || (addr8 == `HLT_OFS_CLKSEL) ||
             (addr8 == `HLT_OFS_COUNT) || (addr8 == `HLT_OFS_PERIOD) ||
             (addr8 == `HLT_OFS_LIMIT) || (addr8 == `HLT_OFS_EXT_RESET_SOURCE_SEL);
// Writes land only on the edge that completes the access
assign wr = psel && penable && pready_q && pwrite && hit;

always_comb
begin
    main_d = main_q;
    limit_d = limit_q;
    clksel_d = clksel_q;
    ext_reset_source_sel_d = ext_reset_source_sel_q;
    period_d = period_q;
    pready_d = psel && penable && !pready_q;
    pslverr_d = psel && penable && !pready_q && !hit;
    prdata_d = prdata_q;
    // Read data only moves on a read, so it holds through writes
    if (psel && penable && !pready_q && !pwrite)
    begin
        prdata_d = 32'h0000_0000;
        case (addr8)
            `HLT_OFS_MAIN: prdata_d[7:0] = main_q;
            `HLT_OFS_CLKSEL: prdata_d[3:0] = clksel_q;
            `HLT_OFS_COUNT: prdata_d[7:0] = count_q;
            `HLT_OFS_PERIOD: prdata_d[7:0] = period_q;
            `HLT_OFS_LIMIT: prdata_d[7:0] = limit_q;
            `HLT_OFS_EXT_RESET_SOURCE_SEL: prdata_d[3:0] = ext_reset_source_sel_q;
            default: prdata_d = 32'h0000_0000;
        endcase
    end
    if (wr)
    begin
        case (addr8)
            `HLT_OFS_MAIN: main_d = pwdata[7:0];
            `HLT_OFS_CLKSEL: clksel_d = pwdata[3:0];
            `HLT_OFS_PERIOD: period_d = pwdata[7:0];
            `HLT_OFS_LIMIT: limit_d = pwdata[7:0];
            `HLT_OFS_EXT_RESET_SOURCE_SEL: ext_reset_source_sel_d = pwdata[3:0];
            default: ;
        endcase
    end
    // One-shot end wins over a software write in the same cycle
    if (hw_off)
    begin
        main_d.on = 1'b0;
    end
end

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        main_q <= `HLT_RST_MAIN;
        limit_q <= `HLT_RST_LIMIT;
        clksel_q <= `HLT_RST_CLKSEL;
        ext_reset_source_sel_q <= `HLT_RST_EXT_RESET_SOURCE_SEL;
        period_q <= `HLT_RST_PERIOD;
        prdata_q <= 32'h0000_0000;
        pready_q <= 1'b0;
        pslverr_q <= 1'b0;
    end
    else
    begin
        main_q <= main_d;
        limit_q <= limit_d;
        clksel_q <= clksel_d;
        ext_reset_source_sel_q <= ext_reset_source_sel_d;
        period_q <= period_d;
        prdata_q <= prdata_d;
        pready_q <= pready_d;
        pslverr_q <= pslverr_d;
    end
end

assign prdata = prdata_q;
assign pready = pready_q;
assign pslverr = pslverr_q;

// ============================================================
// Clock edge, enable sync, prescaler, prescaler sync
// ============================================================
logic clk_sel;
logic clk_prev_q, clk_prev_d;
logic in_tick;
logic [1:0] en_sh_q, en_sh_d;
logic en_eff;
logic [6:0] pre_cnt_q, pre_cnt_d;
logic [6:0] pre_mask;
logic pre_pulse;
logic ps_meta_q, ps_meta_d;
logic ps_out_q, ps_out_d;
logic tmr_tick;

assign clk_sel = (clksel_q >= `HLT_CS_FIRST_RSVD) ? 1'b0 :
                 clk_src_s[clksel_q];
// Instruction clock source advances on every bus clock
assign in_tick = (clksel_q == `HLT_CS_INSTR) ? 1'b1 :
                 limit_q.input_clock_polarity ? (!clk_sel && clk_prev_q) :
                 (clk_sel && !clk_prev_q);
// Polarity is sampled live; changing it while on may cause a false edge
assign en_eff = limit_q.enable_sync_to_timer_clock ? en_sh_q[1] :
                main_q.on;
assign pre_mask = 7'((`HLT_PRE_ONE << main_q.prescale_select) - 1);
assign pre_pulse = in_tick && en_eff &&
                   ((pre_cnt_q & pre_mask) == pre_mask);
// Sync path delays ticks two cycles but keeps count updates coherent
assign tmr_tick = limit_q.prescaler_sync_enable ?
                  (ps_out_q && !cpu_sleep) : pre_pulse;

always_comb
begin
    clk_prev_d = clk_sel;
    en_sh_d = en_sh_q;
    if (in_tick)
    begin
        en_sh_d = {en_sh_q[0], main_q.on};
    end
    pre_cnt_d = pre_cnt_q;
    if (!en_eff)
    begin
        pre_cnt_d = 7'h00;
    end
    else if (pre_pulse)
    begin
        pre_cnt_d = 7'h00;
    end
    else if (in_tick)
    begin
        pre_cnt_d = pre_cnt_q + 7'h01;
    end
    ps_meta_d = pre_pulse;
    ps_out_d = ps_meta_q;
end

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        clk_prev_q <= 1'b0;
        en_sh_q <= 2'b00;
        pre_cnt_q <= 7'h00;
        ps_meta_q <= 1'b0;
        ps_out_q <= 1'b0;
    end
    else
    begin
        clk_prev_q <= clk_prev_d;
        en_sh_q <= en_sh_d;
        pre_cnt_q <= pre_cnt_d;
        ps_meta_q <= ps_meta_d;
        ps_out_q <= ps_out_d;
    end
end

// ============================================================
// Reset source, mode control, count and postscaler
// ============================================================
logic ext_sel;
logic ext_prev_q, ext_prev_d;
logic ext_rise;
logic ext_fall;
logic edge_hit;
logic lvl_reset;
logic is_edge_mode;
logic is_lvl_mode;
logic counting;
logic match_tick;
hlt_run_e run_q, run_d;
logic [3:0] post_cnt_q, post_cnt_d;
logic match_out_q, match_out_d;
logic post_out_q, post_out_d;

assign ext_sel = (ext_reset_source_sel_q == `HLT_EXT_RESET_SOURCE_SEL_RSVD ||
                  ext_reset_source_sel_q == 4'(OWN_EXT_RESET_SOURCE_SEL_CODE)) ? 1'b0 :
                 ext_src_s[ext_reset_source_sel_q];
assign ext_rise = ext_sel && !ext_prev_q;
assign ext_fall = !ext_sel && ext_prev_q;
assign is_edge_mode = (limit_q.mode == HLT_MODE_EDGE_RISE) ||
                      (limit_q.mode == HLT_MODE_EDGE_FALL) ||
                      (limit_q.mode == HLT_MODE_EDGE_BOTH);
assign is_lvl_mode = (limit_q.mode == HLT_MODE_LVL_LOW) ||
                     (limit_q.mode == HLT_MODE_LVL_HIGH);
assign edge_hit = (limit_q.mode == HLT_MODE_EDGE_RISE) ? ext_rise :
                  (limit_q.mode == HLT_MODE_EDGE_FALL) ? ext_fall :
                  (ext_rise || ext_fall);
assign lvl_reset = (limit_q.mode == HLT_MODE_LVL_HIGH) ? ext_sel :
                   !ext_sel;
assign counting = is_edge_mode ? (run_q == HLT_RUN) :
                  is_lvl_mode ? (en_eff && !lvl_reset) :
                  en_eff;
assign match_tick = tmr_tick && counting && (count_q == period_q);
assign hw_off = is_lvl_mode && match_tick;

always_comb
begin
    ext_prev_d = ext_sel;
    run_d = run_q;
    case (run_q)
        HLT_IDLE:
        begin
            if (is_edge_mode && en_eff && edge_hit)
            begin
                run_d = HLT_RUN;
            end
            else if (is_lvl_mode && lvl_reset)
            begin
                run_d = HLT_HELD;
            end
        end
        HLT_RUN:
        begin
            if (match_tick || !is_edge_mode)
            begin
                run_d = HLT_IDLE;
            end
        end
        HLT_HELD:
        begin
            if (!is_lvl_mode || !lvl_reset)
            begin
                run_d = HLT_IDLE;
            end
        end
        default: run_d = HLT_IDLE;
    endcase
    if (!main_q.on)
    begin
        run_d = HLT_IDLE;
    end
    count_d = count_q;
    if (wr && addr8 == `HLT_OFS_COUNT)
    begin
        count_d = pwdata[7:0];
    end
    else if (is_lvl_mode && lvl_reset)
    begin
        count_d = 8'h00;
    end
    else if (match_tick)
    begin
        count_d = 8'h00;
    end
    else if (tmr_tick && counting)
    begin
        count_d = count_q + 8'h01;
    end
    post_cnt_d = post_cnt_q;
    post_out_d = 1'b0;
    match_out_d = match_tick;
    if (!main_q.on)
    begin
        post_cnt_d = 4'h0;
    end
    else if (match_tick)
    begin
        if (post_cnt_q == main_q.postscale_select)
        begin
            post_cnt_d = 4'h0;
            post_out_d = 1'b1;
        end
        else
        begin
            post_cnt_d = post_cnt_q + 4'h1;
        end
    end
end

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ext_prev_q <= 1'b0;
        run_q <= HLT_IDLE;
        count_q <= `HLT_RST_COUNT;
        post_cnt_q <= 4'h0;
        match_out_q <= 1'b0;
        post_out_q <= 1'b0;
    end
    else
    begin
        ext_prev_q <= ext_prev_d;
        run_q <= run_d;
        count_q <= count_d;
        post_cnt_q <= post_cnt_d;
        match_out_q <= match_out_d;
        post_out_q <= post_out_d;
    end
end

assign period_match_out = match_out_q;
assign postscaled_out = post_out_q;

endmodule : hlt_timer_ctrl
`default_nettype wire

// [hlt_timer_ctrl_checker.sv]
// Port assertions for the limit timer control block
`timescale 1ns/10ps
`default_nettype none
module hlt_timer_ctrl_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ========================================
    // Bus answer checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_ready_answer: assert property
        (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    chk_ready_pulse: assert property
        (pready |=> !pready)
        else $error("ready stood too long");
    chk_ready_cause: assert property
        (pready |-> $past(psel && penable && !pready))
        else $error("ready without access");
    chk_err_with_ready: assert property
        (pslverr |-> pready)
        else $error("error flag without ready");
    chk_upper_zero: assert property
        (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    // Reserved space starts right above the reset select word
    chk_unmapped_err: assert property
        (psel && penable && !pready && paddr[7:0] > 8'h14
            |=> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property
        (psel && penable && !pready && paddr[7:0] <= 8'h14
            && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("mapped access refused");
    chk_rdata_hold: assert property
        (!(pready && !pwrite) |-> $stable(prdata))
        else $error("read data moved outside a read");
endmodule : hlt_timer_ctrl_checker

bind hlt_timer_ctrl hlt_timer_ctrl_checker #(.ADDR_W(ADDR_W)) u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
);
`default_nettype wire

// [hlt_src_model.sv]
// Model of the on-chip sources feeding timer clock and reset inputs
`timescale 1ns/10ps
`default_nettype none
module hlt_src_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] rst_level,
    output logic [15:0] clock_sources,
    output logic [15:0] ext_reset_sources
);
    // ========================================
    // Peripheral clock: period of eight bus clocks, free running
    logic [2:0] div_q;
    logic [2:0] div_d;

    always_comb
    begin
        div_d = div_q + 3'd1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_q <= 3'd0;
        else
            div_q <= div_d;
    end

    // Code 0 is the bus clock inside the block, so its line stays low
    assign clock_sources = {{15{div_q[2]}}, 1'b0};
    assign ext_reset_sources = rst_level;
endmodule : hlt_src_model
`default_nettype wire

// [hlt_timer_ctrl_tb_top.sv]
// Self-checking testbench for the limit timer control block
`timescale 1ns/10ps
`default_nettype none
`include "hlt_timer_map.svh"
module hlt_timer_ctrl_tb_top
    import hlt_pkg::*;
;
    // ========================================
    // Signals
    logic pclk, presetn, psel, penable, pwrite, cpu_sleep, pready, pslverr;
    logic match, post, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, v, seed;
    logic [15:0] clk_src, rst_src, rst_level;
    logic [7:0] ofs [6];
    logic [7:0] rv [6];
    int bad_count, samples_checked, n, p, ps, po, dv;

    hlt_src_model u_src (.pclk(pclk), .presetn(presetn),
        .rst_level(rst_level), .clock_sources(clk_src),
        .ext_reset_sources(rst_src));
    hlt_timer_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_sleep(cpu_sleep), .clock_sources(clk_src),
        .ext_reset_sources(rst_src), .period_match_out(match),
        .postscaled_out(post));

    // ========================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic conclude;
        if (bad_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            bad_count++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Cycles between two pulses; the first pulse only aligns
    task automatic gap(input bit which, input int lim, output int cnt);
        int i;
        for (i = 0; i < 2 * lim; i++)
        begin
            @(posedge pclk);
            if ((which ? post : match) === 1'b1)
                break;
        end
        cnt = 0;
        do
        begin
            @(posedge pclk);
            cnt++;
        end while ((which ? post : match) !== 1'b1 && cnt < lim);
    endtask : gap

    // ========================================
    // Clock and main sequence
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cpu_sleep = 1'b0;
        rst_level = 16'h0;
        bad_count = 0;
        samples_checked = 0;
        seed = 32'h56d32230;
        ofs = '{`HLT_OFS_MAIN, `HLT_OFS_CLKSEL, `HLT_OFS_COUNT,
                `HLT_OFS_PERIOD, `HLT_OFS_LIMIT, `HLT_OFS_EXT_RESET_SOURCE_SEL};
        rv = '{`HLT_RST_MAIN, {4'h0, `HLT_RST_CLKSEL}, `HLT_RST_COUNT,
               `HLT_RST_PERIOD, `HLT_RST_LIMIT, {4'h0, `HLT_RST_EXT_RESET_SOURCE_SEL}};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, ofs[i], 32'h0);
            check(rd, {24'h0, rv[i]});
        end
        apb(1'b0, 8'h18, 32'h0);
        check({rd[31:1], err}, 32'h1);
        apb(1'b1, 8'hfc, 32'hff);
        check({31'h0, err}, 32'h1);
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            apb(1'b1, `HLT_OFS_LIMIT, seed);
            apb(1'b0, `HLT_OFS_LIMIT, 32'h0);
            check(rd, {24'h0, seed[7:0]});
            apb(1'b1, `HLT_OFS_EXT_RESET_SOURCE_SEL, seed >> 8);
            apb(1'b0, `HLT_OFS_EXT_RESET_SOURCE_SEL, 32'h0);
            check(rd, {28'h0, seed[11:8]});
        end
        apb(1'b1, `HLT_OFS_EXT_RESET_SOURCE_SEL, 32'hffffffff);
        apb(1'b0, `HLT_OFS_EXT_RESET_SOURCE_SEL, 32'h0);
        check(rd, 32'h0000000f);
        // Bus clock and the slow peripheral clock, random sync bits
        for (int t = 0; t < 6; t++)
        begin
            seed = lfsr(seed);
            p = 2 + seed[2:0];
            ps = seed[4:3];
            po = seed[6:5];
            dv = t[0] ? 8 : 1;
            apb(1'b1, `HLT_OFS_MAIN, 32'h0);
            // Polarity only touched while the timer is off
            apb(1'b1, `HLT_OFS_LIMIT, {24'h0, seed[9:7], 5'h0});
            apb(1'b1, `HLT_OFS_CLKSEL, t[0] ? 32'h6 : 32'h0);
            apb(1'b1, `HLT_OFS_PERIOD, p);
            apb(1'b1, `HLT_OFS_COUNT, 32'h0);
            apb(1'b1, `HLT_OFS_MAIN, {24'h0, 1'b1, ps[2:0], po[3:0]});
            gap(1'b0, 4096, n);
            check(n, ((p + 1) * dv) << ps);
            gap(1'b1, 8192, n);
            check(n, (po + 1) * (((p + 1) * dv) << ps));
        end
        apb(1'b1, `HLT_OFS_MAIN, 32'h0);
        // Enable sync may let two slow ticks pass before the stop bites
        repeat (40) @(posedge pclk);
        apb(1'b0, `HLT_OFS_COUNT, 32'h0);
        v = rd;
        repeat (20) @(posedge pclk);
        apb(1'b0, `HLT_OFS_COUNT, 32'h0);
        check(rd, v);
        check({31'h0, v <= p}, 32'h1);
        // Sleeping with prescaler sync set must freeze the count
        apb(1'b1, `HLT_OFS_CLKSEL, 32'h0);
        apb(1'b1, `HLT_OFS_LIMIT, 32'h80);
        cpu_sleep <= 1'b1;
        apb(1'b1, `HLT_OFS_MAIN, 32'h80);
        apb(1'b0, `HLT_OFS_COUNT, 32'h0);
        v = rd;
        repeat (20) @(posedge pclk);
        apb(1'b0, `HLT_OFS_COUNT, 32'h0);
        check(rd, v);
        cpu_sleep <= 1'b0;
        // High reset level on comparator source holds the count at zero
        apb(1'b1, `HLT_OFS_MAIN, 32'h0);
        rst_level <= 16'h0002;
        apb(1'b1, `HLT_OFS_EXT_RESET_SOURCE_SEL, 32'h1);
        apb(1'b1, `HLT_OFS_LIMIT, 32'h17);
        apb(1'b1, `HLT_OFS_COUNT, 32'h0);
        apb(1'b1, `HLT_OFS_MAIN, 32'h80);
        repeat (20) @(posedge pclk);
        apb(1'b0, `HLT_OFS_COUNT, 32'h0);
        check(rd, 32'h0);
        // Releasing the level lets one period run, then hardware clears on
        rst_level <= 16'h0000;
        repeat (40) @(posedge pclk);
        apb(1'b0, `HLT_OFS_MAIN, 32'h0);
        check(rd, 32'h0);
        conclude();
    end
endmodule : hlt_timer_ctrl_tb_top
`default_nettype wire
